// File: include/mstpm_pkg.sv
// Constants and types for the step timer and PWM manager
`default_nettype none
package mstpm_pkg;
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TW            = 8;
    localparam int unsigned SRW           = 4;
    localparam logic [7:0]  TIM_MAX       = 8'hFF;
    localparam logic [7:0]  TIM_LOW       = 8'h55;
    localparam logic [7:0]  REG_RST       = 8'h00;
    localparam logic [3:0]  SR_MIN        = 4'h0;
    localparam logic [3:0]  SR_MAX        = 4'hF;
    localparam logic [3:0]  SR_RST        = 4'h0;
    // Base timer tick, 4 MHz cpu reference: 0.5 us per count at code 0
    localparam int unsigned TICK_NS       = 500;
    localparam int unsigned TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
    // Off times and comparator filter blanking time in ns
    localparam int unsigned OFF0_NS       = 5000;
    localparam int unsigned OFF1_NS       = 10000;
    localparam int unsigned OFF2_NS       = 15000;
    localparam int unsigned OFF3_NS       = 30000;
    localparam int unsigned OFFS_NS       = 1250;
    localparam int unsigned FILT_NS       = 2500;
    localparam int unsigned FILT_CYC      = FILT_NS / CLK_PERIOD_NS;
    // Window periods in ns for each rate code
    localparam int unsigned WIN_NS [16] = '{40000, 50000, 55249, 64935, 80000, 100000,
        160000, 319489, 641026, 800000, 877193, 1040583, 1280410, 1600000,
        2564103, 5128205};
    typedef enum logic [1:0] {
        MSTPM_CFG   = 2'b00,
        MSTPM_SW    = 2'b01,
        MSTPM_ESTOP = 2'b10,
        MSTPM_AUTO  = 2'b11
    } mstpm_mode_t;
endpackage
`default_nettype wire

// File: rtl/mstpm_window_gen.sv
// Measurement window generator: window low for the off time each period
`timescale 1ns/10ps
`default_nettype none
module mstpm_window_gen #(
    parameter int unsigned CW = 20
) (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [3:0] window_rate_field,
    input  wire logic [1:0] off_time_field,
    input  wire logic       sensor_mode_bit,
    output logic            window_n,
    output logic            window_end
);
    localparam int unsigned PCYC [16] = '{
        mstpm_pkg::WIN_NS[0]/10, mstpm_pkg::WIN_NS[1]/10, mstpm_pkg::WIN_NS[2]/10,
        mstpm_pkg::WIN_NS[3]/10, mstpm_pkg::WIN_NS[4]/10, mstpm_pkg::WIN_NS[5]/10,
        mstpm_pkg::WIN_NS[6]/10, mstpm_pkg::WIN_NS[7]/10, mstpm_pkg::WIN_NS[8]/10,
        mstpm_pkg::WIN_NS[9]/10, mstpm_pkg::WIN_NS[10]/10, mstpm_pkg::WIN_NS[11]/10,
        mstpm_pkg::WIN_NS[12]/10, mstpm_pkg::WIN_NS[13]/10, mstpm_pkg::WIN_NS[14]/10,
        mstpm_pkg::WIN_NS[15]/10};
    initial begin
        if (CW < 20) $error("window counter too narrow");
    end
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] per;
    logic [CW-1:0] off;
    always_comb begin
        per = CW'(PCYC[window_rate_field]);
        if (sensor_mode_bit) begin
            off = CW'(mstpm_pkg::OFFS_NS / mstpm_pkg::CLK_PERIOD_NS);
        end else begin
            case (off_time_field)
                2'h0:    off = CW'(mstpm_pkg::OFF0_NS / mstpm_pkg::CLK_PERIOD_NS);
                2'h1:    off = CW'(mstpm_pkg::OFF1_NS / mstpm_pkg::CLK_PERIOD_NS);
                2'h2:    off = CW'(mstpm_pkg::OFF2_NS / mstpm_pkg::CLK_PERIOD_NS);
                default: off = CW'(mstpm_pkg::OFF3_NS / mstpm_pkg::CLK_PERIOD_NS);
            endcase
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= '0;
        end else if (cnt_r >= per - CW'(1)) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + CW'(1);
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            window_n   <= 1'b1;
            window_end <= 1'b0;
        end else begin
            window_n   <= (cnt_r >= off);
            window_end <= (cnt_r == off);
        end
    end
endmodule // mstpm_window_gen
`default_nettype wire

// File: rtl/mstpm_comp_filter.sv
// Current comparator blanking filter after PWM switch-on
`timescale 1ns/10ps
`default_nettype none
module mstpm_comp_filter #(
    parameter int unsigned FW = 9
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic enable,
    input  wire logic pwm_on_start,
    input  wire logic trip_in,
    output logic      trip_out
);
    initial begin
        if ((1 << FW) <= mstpm_pkg::FILT_CYC) $error("filter counter too narrow");
    end
    logic [FW-1:0] blank_r;
    // Blanking, not debouncing: ignores trips for a fixed time after switch-on
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            blank_r <= '0;
        end else if (pwm_on_start && enable) begin
            blank_r <= FW'(mstpm_pkg::FILT_CYC);
        end else if (blank_r != '0) begin
            blank_r <= blank_r - FW'(1);
        end
    end
    always_comb begin
        trip_out = trip_in && (blank_r == '0);
    end
endmodule // mstpm_comp_filter
`default_nettype wire

// File: rtl/mstpm_core.sv
// Step timer register access, step ratio control and PWM manager
`timescale 1ns/10ps
`default_nettype none
module mstpm_core #(
    parameter int unsigned TIMER_W = mstpm_pkg::TW
) (
    input  wire logic               clk,
    input  wire logic               resetn,
    input  wire logic               output_enable_bit,
    input  wire logic               auto_switch_select,
    input  wire logic               direct_access_bit,
    input  wire logic               voltage_current_select,
    input  wire logic               sensor_mode_bit,
    input  wire logic               comparator_filter_enable,
    input  wire logic [3:0]         window_rate_field,
    input  wire logic [1:0]         off_time_field,
    input  wire logic               emergency_n,
    input  wire logic               current_sense_input,
    input  wire logic               current_reference_pin,
    input  wire logic               timer_pwm_in,
    input  wire logic               zero_event,
    input  wire logic               demag_event,
    input  wire logic               wr_en,
    input  wire logic [2:0]         wr_sel,
    input  wire logic [TIMER_W-1:0] wr_data,
    input  wire logic               flag_set_down,
    input  wire logic               flag_set_up,
    input  wire logic               flag_clr_down,
    input  wire logic               flag_clr_up,
    input  wire logic [5:0]         phase_out_pattern,
    input  wire logic [5:0]         odd_group_sel,
    output logic [TIMER_W-1:0]      commutation_timer,
    output logic [TIMER_W-1:0]      previous_zero_capture,
    output logic [TIMER_W-1:0]      current_zero_capture,
    output logic [TIMER_W-1:0]      commutation_compare,
    output logic [TIMER_W-1:0]      demagnetization_register,
    output logic [3:0]              step_ratio_field,
    output logic                    ratio_down_flag,
    output logic                    ratio_up_flag,
    output logic                    commutation_event,
    output logic                    pwm_out,
    output logic                    zero_cross_sample,
    output logic [5:0]              channel_out,
    output logic [5:0]              channel_oe
);
    initial begin
        if (TIMER_W != 8) $error("timer width must be 8");
    end
    localparam logic [2:0] SEL_TIM  = 3'h0;
    localparam logic [2:0] SEL_ZPRV = 3'h1;
    localparam logic [2:0] SEL_ZREG = 3'h2;
    localparam logic [2:0] SEL_COMP = 3'h3;
    localparam logic [2:0] SEL_DEM  = 3'h4;
    localparam logic [2:0] SEL_SR   = 3'h5;
    // Wide enough for the slowest ratio code: tick base shifted by 15
    localparam int unsigned PSW = 21;

    mstpm_pkg::mstpm_mode_t mode;
    logic                   clk_en;
    logic [PSW-1:0]         pre_r;
    logic [PSW-1:0]         pre_lim;
    logic                   tick;
    logic                   tim_max;
    logic                   auto_up;
    logic                   auto_down;
    logic                   sw_step;
    logic                   win_n;
    logic                   win_end;
    logic                   trip_raw;
    logic                   trip;
    logic                   cur_pwm_r;
    logic                   pwm_start;
    logic                   pwm_sel;
    logic                   pwm_prev_r;

    always_comb begin
        mode = mstpm_pkg::mstpm_mode_t'({auto_switch_select, output_enable_bit});
    end
    // Writes land only where the mode allows them
    function automatic logic wr_ok(input logic [2:0] sel, input logic [1:0] m, input logic ce);
        if (!ce) begin
            wr_ok = 1'b1;
        end else if (m == 2'b01) begin
            wr_ok = (sel == SEL_COMP) || (sel == SEL_DEM);
        end else begin
            wr_ok = (sel == SEL_DEM);
        end
    endfunction

    always_comb begin
        clk_en    = output_enable_bit && !direct_access_bit && emergency_n;
        pre_lim   = PSW'(mstpm_pkg::TICK_CYC) << step_ratio_field;
        tick      = clk_en && (pre_r >= pre_lim - PSW'(1));
        tim_max   = (commutation_timer == mstpm_pkg::TIM_MAX);
        auto_up   = (mode == mstpm_pkg::MSTPM_AUTO) && tick && tim_max
                    && (step_ratio_field != mstpm_pkg::SR_MAX);
        auto_down = (mode == mstpm_pkg::MSTPM_AUTO) && clk_en && zero_event
                    && (commutation_timer < mstpm_pkg::TIM_LOW)
                    && (step_ratio_field != mstpm_pkg::SR_MIN);
        sw_step   = (mode == mstpm_pkg::MSTPM_SW) && clk_en && tick
                    && (commutation_timer == commutation_compare);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pre_r <= '0;
        end else if (!clk_en || tick) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + PSW'(1);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            commutation_event <= 1'b0;
        end else begin
            commutation_event <= sw_step;
        end
    end

    // Timer and related registers; shifts keep values consistent with ratio
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            commutation_timer        <= mstpm_pkg::REG_RST;
            previous_zero_capture    <= mstpm_pkg::REG_RST;
            current_zero_capture     <= mstpm_pkg::REG_RST;
            commutation_compare      <= mstpm_pkg::REG_RST;
            demagnetization_register <= mstpm_pkg::REG_RST;
        end else if (auto_up) begin
            commutation_timer        <= commutation_timer >> 1;
            previous_zero_capture    <= previous_zero_capture >> 1;
            current_zero_capture     <= current_zero_capture >> 1;
            commutation_compare      <= commutation_compare >> 1;
            demagnetization_register <= demagnetization_register >> 1;
        end else if (auto_down) begin
            previous_zero_capture    <= current_zero_capture;
            current_zero_capture     <= commutation_timer << 1;
            commutation_timer        <= '0;
            commutation_compare      <= commutation_compare << 1;
            demagnetization_register <= demagnetization_register << 1;
        end else begin
            if (wr_en && wr_ok(wr_sel, mode, clk_en)) begin
                case (wr_sel)
                    SEL_TIM:  commutation_timer        <= wr_data;
                    SEL_ZPRV: previous_zero_capture    <= wr_data;
                    SEL_ZREG: current_zero_capture     <= wr_data;
                    SEL_COMP: commutation_compare      <= wr_data;
                    SEL_DEM:  demagnetization_register <= wr_data;
                    default:  ;
                endcase
            end
            // Allowed writes never touch these registers while running, so events are not lost
            if (mode == mstpm_pkg::MSTPM_AUTO && clk_en && zero_event) begin
                previous_zero_capture <= current_zero_capture;
                current_zero_capture  <= commutation_timer;
                commutation_timer     <= '0;
            end else if (sw_step) begin
                commutation_timer <= '0;
            end else if (tick && !tim_max) begin
                commutation_timer <= commutation_timer + 8'h01;
            end
        end
    end

    // Step ratio: direct writes only with the clock stopped
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            step_ratio_field <= mstpm_pkg::SR_RST;
        end else if (!clk_en) begin
            if (wr_en && wr_sel == SEL_SR) begin
                step_ratio_field <= wr_data[3:0];
            end
        end else if (auto_up) begin
            step_ratio_field <= step_ratio_field + 4'h1;
        end else if (auto_down) begin
            step_ratio_field <= step_ratio_field - 4'h1;
        end else if (sw_step && ratio_up_flag && step_ratio_field != mstpm_pkg::SR_MAX) begin
            step_ratio_field <= step_ratio_field + 4'h1;
        end else if (sw_step && ratio_down_flag && !ratio_up_flag
                     && step_ratio_field != mstpm_pkg::SR_MIN) begin
            step_ratio_field <= step_ratio_field - 4'h1;
        end
    end

    // Ratio flags: software request in switched, hardware set in auto
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ratio_up_flag <= 1'b0;
        end else if (auto_up || (mode == mstpm_pkg::MSTPM_SW && flag_set_up)) begin
            ratio_up_flag <= 1'b1;
        end else if (sw_step || (mode == mstpm_pkg::MSTPM_AUTO && flag_clr_up)) begin
            ratio_up_flag <= 1'b0;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ratio_down_flag <= 1'b0;
        end else if (auto_down || (mode == mstpm_pkg::MSTPM_SW && flag_set_down)) begin
            ratio_down_flag <= 1'b1;
        end else if ((sw_step && !ratio_up_flag)
                     || (mode == mstpm_pkg::MSTPM_AUTO && flag_clr_down)) begin
            ratio_down_flag <= 1'b0;
        end
    end

    mstpm_window_gen #(
        .CW (PSW)
    ) u_win (
        .clk               (clk),
        .resetn            (resetn),
        .window_rate_field (window_rate_field),
        .off_time_field    (off_time_field),
        .sensor_mode_bit   (sensor_mode_bit),
        .window_n          (win_n),
        .window_end        (win_end)
    );

    always_comb begin
        trip_raw  = current_sense_input && !current_reference_pin;
        pwm_start = voltage_current_select ? win_end : (timer_pwm_in && !pwm_prev_r);
    end

    mstpm_comp_filter #(
        .FW (9)
    ) u_filt (
        .clk          (clk),
        .resetn       (resetn),
        .enable       (comparator_filter_enable),
        .pwm_on_start (pwm_start),
        .trip_in      (trip_raw),
        .trip_out     (trip)
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pwm_prev_r <= 1'b0;
        end else begin
            pwm_prev_r <= timer_pwm_in;
        end
    end

    // Current mode PWM latch
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur_pwm_r <= 1'b0;
        end else if (!win_n || trip) begin
            cur_pwm_r <= 1'b0;
        end else if (win_end) begin
            cur_pwm_r <= 1'b1;
        end
    end

    always_comb begin
        pwm_sel = voltage_current_select ? cur_pwm_r : (timer_pwm_in && !trip);
    end

    // Zero-cross sampling only with PWM off or inside a window
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            zero_cross_sample <= 1'b0;
        end else if (voltage_current_select) begin
            zero_cross_sample <= !sensor_mode_bit && !win_n;
        end else begin
            zero_cross_sample <= !sensor_mode_bit && !timer_pwm_in;
        end
    end

    // Channel manager: PWM to odd or even group, emergency forces release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pwm_out     <= 1'b0;
            channel_out <= 6'h00;
            channel_oe  <= 6'h00;
        end else begin
            pwm_out <= pwm_sel;
            for (int i = 0; i < 6; i++) begin
                channel_out[i] <= phase_out_pattern[i] && (odd_group_sel[i] ? pwm_sel : 1'b1);
            end
            channel_oe <= (output_enable_bit && emergency_n) ? 6'h3F : 6'h00;
        end
    end

    AST_UP_HALVES: assert property (@(posedge clk) disable iff (!resetn)
        auto_up |=> (commutation_timer == 8'h7F) && ratio_up_flag)
        else $error("ratio up did not halve timer");
    AST_SR_FROZEN: assert property (@(posedge clk) disable iff (!resetn)
        $past(clk_en) && clk_en |-> (step_ratio_field == $past(step_ratio_field))
        || (step_ratio_field == $past(step_ratio_field) + 4'h1)
        || (step_ratio_field == $past(step_ratio_field) - 4'h1))
        else $error("ratio jumped while running");
    AST_AUTO_RO: assert property (@(posedge clk) disable iff (!resetn)
        (mode == mstpm_pkg::MSTPM_AUTO) && clk_en && wr_en && wr_sel == SEL_COMP
        && !auto_up && !auto_down |=> $stable(commutation_compare))
        else $error("compare written in auto mode");
    AST_CFG_WR: assert property (@(posedge clk) disable iff (!resetn)
        !clk_en && wr_en && wr_sel == SEL_ZREG |=> current_zero_capture == $past(wr_data))
        else $error("capture write lost in configuration");
    AST_STOP_CLK: assert property (@(posedge clk) disable iff (!resetn)
        !clk_en && !(wr_en && wr_sel == SEL_TIM) |=> $stable(commutation_timer))
        else $error("timer moved with clock disabled");
    AST_OE_OFF: assert property (@(posedge clk) disable iff (!resetn)
        !output_enable_bit |=> channel_oe == 6'h00)
        else $error("outputs driven with enable low");
    AST_CUR_TRIP: assert property (@(posedge clk) disable iff (!resetn)
        voltage_current_select && cur_pwm_r && trip |=> !cur_pwm_r)
        else $error("current trip did not end pwm");
    AST_ZC_OFF: assert property (@(posedge clk) disable iff (!resetn)
        !voltage_current_select && timer_pwm_in |=> !zero_cross_sample)
        else $error("sampling during pwm on");
    AST_SW_UP: assert property (@(posedge clk) disable iff (!resetn)
        sw_step && ratio_up_flag && (step_ratio_field != mstpm_pkg::SR_MAX)
        |=> step_ratio_field == $past(step_ratio_field) + 4'h1)
        else $error("switched ratio request not applied");
    AST_DOWN_RESTART: assert property (@(posedge clk) disable iff (!resetn)
        auto_down |=> (commutation_timer == 8'h00) && ratio_down_flag)
        else $error("ratio down did not restart timer");
    AST_WIN_PWM_OFF: assert property (@(posedge clk) disable iff (!resetn)
        !win_n |=> !cur_pwm_r)
        else $error("pwm on inside window");
    AST_ZC_WIN: assert property (@(posedge clk) disable iff (!resetn)
        voltage_current_select && !sensor_mode_bit && !win_n |=> zero_cross_sample)
        else $error("no sampling inside window");
endmodule // mstpm_core
`default_nettype wire

// File: tb/mstpm_drive_model.sv
// Power stage and current sense comparator model
`timescale 1ns/10ps
`default_nettype none
module mstpm_drive_model #(
    parameter int unsigned RISE_CYC = 100
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic pwm_on,
    output logic      sense,
    output logic      ref_level
);
    int unsigned ramp_r;
    // Winding current ramps while driven, collapses when released
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            ramp_r <= 0;
        else if (!pwm_on)
            ramp_r <= 0;
        else if (ramp_r < RISE_CYC)
            ramp_r <= ramp_r + 1;
    end
    assign sense     = (ramp_r >= RISE_CYC);
    assign ref_level = 1'b0;
endmodule // mstpm_drive_model
`default_nettype wire

// File: tb/test_motor_step_timer_pwm_manager.sv
// Self-checking bench for the step timer and PWM manager
`timescale 1ns/10ps
`default_nettype none
module test_motor_step_timer_pwm_manager;
    logic       clk, resetn, output_enable_bit, auto_switch_select, direct_access_bit;
    logic       voltage_current_select, sensor_mode_bit, comparator_filter_enable;
    logic       emergency_n, current_sense_input, current_reference_pin, timer_pwm_in;
    logic       zero_event, demag_event, wr_en, flag_set_down, flag_set_up;
    logic       flag_clr_down, flag_clr_up, ratio_down_flag, ratio_up_flag;
    logic       commutation_event, pwm_out, zero_cross_sample;
    logic [3:0] window_rate_field, step_ratio_field;
    logic [1:0] off_time_field;
    logic [2:0] wr_sel;
    logic [7:0] wr_data, commutation_timer, previous_zero_capture, current_zero_capture;
    logic [7:0] commutation_compare, demagnetization_register;
    logic [5:0] phase_out_pattern, odd_group_sel, channel_out, channel_oe;
    int         bad_count, total_checks, n;

    mstpm_core mstpm_core_inst (.clk, .resetn, .output_enable_bit, .auto_switch_select,
        .direct_access_bit, .voltage_current_select, .sensor_mode_bit,
        .comparator_filter_enable, .window_rate_field, .off_time_field, .emergency_n,
        .current_sense_input, .current_reference_pin, .timer_pwm_in, .zero_event,
        .demag_event, .wr_en, .wr_sel, .wr_data, .flag_set_down, .flag_set_up,
        .flag_clr_down, .flag_clr_up, .phase_out_pattern, .odd_group_sel,
        .commutation_timer, .previous_zero_capture, .current_zero_capture,
        .commutation_compare, .demagnetization_register, .step_ratio_field,
        .ratio_down_flag, .ratio_up_flag, .commutation_event, .pwm_out,
        .zero_cross_sample, .channel_out, .channel_oe);
    mstpm_drive_model mstpm_drive_model_inst (.clk, .resetn, .pwm_on(pwm_out),
        .sense(current_sense_input), .ref_level(current_reference_pin));

    task automatic conclude;
        if (bad_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [2:0] sel, input logic [7:0] d);
        wr_en = 1'b1;
        wr_sel = sel;
        wr_data = d;
        cyc(1);
        wr_en = 1'b0;
        cyc(1);
    endtask
    function automatic logic [7:0] rd(input logic [2:0] sel);
        case (sel)
            3'h0: return commutation_timer;
            3'h1: return previous_zero_capture;
            3'h2: return current_zero_capture;
            3'h3: return commutation_compare;
            3'h4: return demagnetization_register;
            default: return {4'h0, step_ratio_field};
        endcase
    endfunction
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask
    // Bounded wait, so a stuck output shows as a large count
    task automatic wait_pwm(input logic v, output int cnt);
        cnt = 0;
        while (pwm_out !== v && cnt < 9000) begin
            cyc(1);
            cnt++;
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        conclude();
    end
    initial begin
        {output_enable_bit, auto_switch_select, direct_access_bit, voltage_current_select,
         sensor_mode_bit, comparator_filter_enable, timer_pwm_in, zero_event, demag_event,
         wr_en, flag_set_down, flag_set_up, flag_clr_down, flag_clr_up} = '0;
        {resetn, wr_sel, wr_data, window_rate_field, off_time_field} = '0;
        emergency_n = 1'b1;
        phase_out_pattern = 6'h15;
        odd_group_sel = 6'h03;
        bad_count = 0;
        total_checks = 0;
        cyc(16);
        resetn = 1'b1;
        cyc(1);
        for (int i = 0; i < 6; i++) check(rd(3'(i)), 8'h00);
        for (int i = 0; i < 5; i++) begin
            wr(3'(i), 8'hA0 + 8'(i));
            check(rd(3'(i)), 8'hA0 + 8'(i));
        end
        wr(3'h5, 8'h03);
        check(rd(3'h5), 8'h03);
        wr(3'h3, 8'h05);
        wr(3'h0, 8'h00);
        output_enable_bit = 1'b1;
        cyc(1);
        wr(3'h5, 8'h07);
        check(rd(3'h5), 8'h03);
        wr(3'h0, 8'hC0);
        check({7'h0, rd(3'h0) < 8'h10}, 8'h01);
        wr(3'h3, 8'h02);
        check(rd(3'h3), 8'h02);
        pulse(flag_set_up);
        check({7'h0, ratio_up_flag}, 8'h01);
        n = 0;
        while (commutation_event !== 1'b1 && n < 3000) begin
            cyc(1);
            n++;
        end
        check({7'h0, commutation_event}, 8'h01);
        cyc(2);
        check(rd(3'h5), 8'h04);
        output_enable_bit = 1'b0;
        cyc(2);
        check({2'h0, channel_oe}, 8'h00);
        wr(3'h3, 8'h11);
        wr(3'h4, 8'h22);
        wr(3'h5, 8'h00);
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h40);
        wr(3'h2, 8'h40);
        auto_switch_select = 1'b1;
        output_enable_bit = 1'b1;
        cyc(1);
        wr(3'h3, 8'h44);
        check(rd(3'h3), 8'h11);
        wr(3'h4, 8'h32);
        check(rd(3'h4), 8'h32);
        wr(3'h5, 8'h05);
        check(rd(3'h5), 8'h00);
        n = 0;
        while (step_ratio_field !== 4'h1 && n < 14000) begin
            cyc(1);
            n++;
        end
        check({ratio_up_flag, 3'h0, step_ratio_field}, 8'h81);
        check(rd(3'h4), 8'h19);
        pulse(zero_event);
        cyc(1);
        check(rd(3'h2), 8'h7F);
        check(rd(3'h1), 8'h20);
        pulse(zero_event);
        cyc(1);
        check({ratio_down_flag, 3'h0, step_ratio_field}, 8'h80);
        check(rd(3'h1), 8'h7F);
        pulse(flag_clr_down);
        check({7'h0, ratio_down_flag}, 8'h00);
        check({7'h0, zero_cross_sample}, 8'h01);
        timer_pwm_in = 1'b1;
        cyc(2);
        check({pwm_out, zero_cross_sample, channel_out}, 8'h95);
        timer_pwm_in = 1'b0;
        cyc(2);
        check({pwm_out, zero_cross_sample, channel_out}, 8'h54);
        voltage_current_select = 1'b1;
        sensor_mode_bit = 1'b1;
        wait_pwm(1'b0, n);
        // Let a pulse left over from voltage mode drain before timing one
        wait_pwm(1'b1, n);
        wait_pwm(1'b0, n);
        wait_pwm(1'b1, n);
        wait_pwm(1'b0, n);
        check(8'(n >= 95 && n <= 110), 8'h01);
        comparator_filter_enable = 1'b1;
        wait_pwm(1'b1, n);
        wait_pwm(1'b0, n);
        check(8'(n >= 245 && n <= 260), 8'h01);
        emergency_n = 1'b0;
        cyc(2);
        check({2'h0, channel_oe}, 8'h00);
        conclude();
    end
endmodule // test_motor_step_timer_pwm_manager
`default_nettype wire
